// [design/crs_card_register_set.sv]
// Purpose: Identification, capability and protection registers of a flash card
// Assumes: Avalon-MM slave on mclk; link clock sampled as plain input
// Notes: Checksums recomputed combinationally from live register contents
//
// The register addresses and the Avalon-MM slave port were left to the implementer.

`timescale 1ns/1ps

// What this block does
// - Busy bit 31 stays low until the power-up routine finishes.
// - Voltage window: bit 7 set, bits 23:15 set, other window bits zero.
// - Access-mode bits 30:29 always read 10, sector addressing.
// - Identification carries CRC7 in bits 7:1, bit 0 reads one.
// - Package kind reads 01; reserved bits and OEM code read zero.
// - Identification holds serial 47:16, date 15:8, revision 55:48.
// - Structure version 3, spec version 4, bits 121:120 zero.
// - Read access time 0x0E, cycle time zero, bus frequency code 0x32.
// - Command class mask reads 0x0F5.
// - Block lengths 9; partial and misaligned access both reported disallowed.
// - Bit 76 zero: no driver-stage register.
// - Legacy size reads 0xFFF and multiplier 7.
// - Sector count 0x00E90000; user capacity shrinks by enhanced area.
// - All four legacy current codes read 7.
// - Erase group size and multiplier 0x1F, protect group 0x0F, enabled.
// - Write speed 4; default ECC and content protection read zero.
// - Host-writable protection and format fields, erasable ones, default zero.
// - Card-specific bit 0 reads one under its 7-bit checksum.
// - One, four or eight data lines, chosen by host.
module crs_card_register_set
   import crs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [crs_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [crs_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [crs_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic link_clk,
   output logic [31:0] operating_conditions,
   output logic [crs_pkg::REG_W-1:0] card_identification,
   output logic [crs_pkg::REG_W-1:0] card_specific_data,
   output logic [7:0] data_lines_en,
   output logic [31:0] user_sectors
);
   import crs_pkg::*;

   logic rst_meta_q;
   logic rst_sync_b;
   logic link_meta_q;
   logic link_sync_q;
   logic link_prev_q;
   logic link_rise;
   logic [7:0] pwr_cnt_q;
   logic pwr_done_q;
   logic link_seen_q;
   logic ack_q;
   logic req;
   logic wr_en;
   logic [31:0] be_mask;
   logic file_grp_q;
   logic copy_q;
   logic perm_prot_q;
   logic tmp_prot_q;
   logic [1:0] file_fmt_q;
   logic [1:0] ecc_q;
   logic [31:0] serial_q;
   logic [7:0] date_q;
   logic [7:0] rev_q;
   logic [31:0] enh_sect_q;
   crs_width_e width_q;
   logic [31:0] ocr_d;
   logic [127:0] cid_d;
   logic [127:0] csd_d;
   logic [31:0] user_d;
   logic [31:0] rdata_d;
   logic [31:0] wmerge;

   // Serial CRC7 over the 120 bits above the checksum field
   function automatic logic [6:0] crc7_of(input logic [119:0] bits);
      logic [6:0] crc;
      logic fb;
      crc = '0;
      for (int i = 119; i >= 0; i--)
      begin
         fb = bits[i] ^ crc[6];
         crc = {crc[5:0], 1'b0} ^ (fb ? CRC7_POLY : 7'h00);
      end
      return crc;
   endfunction

   // Reset release synchroniser
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_b <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_b <= rst_meta_q;
      end
   end

   // Link clock comes from the host; sample it and find its rising edges
   always_ff @(posedge mclk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         link_meta_q <= 1'b0;
         link_sync_q <= 1'b0;
         link_prev_q <= 1'b0;
      end
      else
      begin
         link_meta_q <= link_clk;
         link_sync_q <= link_meta_q;
         link_prev_q <= link_sync_q;
      end
   end

   assign link_rise = link_sync_q & ~link_prev_q;

   // Power-up routine: runs on the host clock edges after reset
   always_ff @(posedge mclk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         pwr_cnt_q <= 8'h00;
         pwr_done_q <= 1'b0;
         link_seen_q <= 1'b0;
      end
      else if (link_rise)
      begin
         link_seen_q <= 1'b1;
         if (pwr_cnt_q == POWERUP_EDGES - 8'h01)
         begin
            pwr_done_q <= 1'b1;
         end
         else if (!pwr_done_q)
         begin
            pwr_cnt_q <= pwr_cnt_q + 8'h01;
         end
      end
   end

   // Bus handshake: one wait cycle, answer on the second edge
   // A write lands only on the edge that ends the wait, where the master sees it accepted
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_q;
   assign wr_en = avs_write & ack_q;

   always_ff @(posedge mclk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         ack_q <= 1'b0;
      end
      else
      begin
         ack_q <= req & ~ack_q;
      end
   end

   always_comb
   begin
      be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   end

   // Host-writable card-specific fields
   always_ff @(posedge mclk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         file_grp_q <= 1'b0;
         copy_q <= 1'b0;
         perm_prot_q <= 1'b0;
         tmp_prot_q <= 1'b0;
         file_fmt_q <= 2'h0;
         ecc_q <= 2'h0;
      end
      else if (wr_en && avs_address == OFS_WRFIELDS && avs_byteenable[1])
      begin
         // Copy and permanent protection are one-time: they only set
         file_grp_q <= avs_writedata[15];
         copy_q <= copy_q | avs_writedata[14];
         perm_prot_q <= perm_prot_q | avs_writedata[13];
         tmp_prot_q <= avs_writedata[12];
         file_fmt_q <= avs_writedata[11:10];
         ecc_q <= avs_writedata[9:8];
      end
      else if (wr_en && avs_address == OFS_CTRL && avs_byteenable[0] && avs_writedata[0])
      begin
         // Erase clears only the erasable fields
         tmp_prot_q <= 1'b0;
         ecc_q <= 2'h0;
      end
   end

   // Per-unit identity loaded by local software
   assign wmerge = avs_writedata & be_mask;

   always_ff @(posedge mclk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         serial_q <= 32'h0000_0000;
         date_q <= 8'h00;
         rev_q <= 8'h00;
         enh_sect_q <= 32'h0000_0000;
      end
      else if (wr_en)
      begin
         unique case (avs_address)
            OFS_SERIAL:
            begin
               serial_q <= wmerge | (serial_q & ~be_mask);
            end
            OFS_DATEREV:
            begin
               if (avs_byteenable[0])
               begin
                  date_q <= avs_writedata[7:0];
               end
               if (avs_byteenable[1])
               begin
                  rev_q <= avs_writedata[15:8];
               end
            end
            OFS_ENHSECT:
            begin
               enh_sect_q <= wmerge | (enh_sect_q & ~be_mask);
            end
            default:
            begin
            end
         endcase
      end
   end

   // Data line width; an illegal code leaves the setting alone
   always_ff @(posedge mclk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         width_q <= CRS_BW_1;
      end
      else if (wr_en && avs_address == OFS_BUSWIDTH && avs_byteenable[0])
      begin
         unique case (avs_writedata[1:0])
            2'h0: width_q <= CRS_BW_1;
            2'h1: width_q <= CRS_BW_4;
            2'h2: width_q <= CRS_BW_8;
            default: width_q <= width_q;
         endcase
      end
   end

   // Register images
   always_comb
   begin
      ocr_d = 32'h0000_0000;
      ocr_d[OC_BUSY] = pwr_done_q;
      ocr_d[30:29] = OC_ACCESS_SECTOR;
      ocr_d[23:15] = OC_HIGH_RANGE;
      ocr_d[7] = OC_LOW_RANGE;

      cid_d = '0;
      cid_d[127:120] = ID_MAKER;
      cid_d[113:112] = ID_PKG_EMBEDDED;
      cid_d[103:56] = ID_PRODUCT;
      cid_d[55:48] = rev_q;
      cid_d[47:16] = serial_q;
      cid_d[15:8] = date_q;
      cid_d[7:1] = crc7_of(cid_d[127:8]);
      cid_d[0] = 1'b1;

      csd_d = '0;
      csd_d[127:126] = CS_STRUCT;
      csd_d[125:122] = CS_SPEC;
      csd_d[119:112] = CS_READ_TIME;
      csd_d[111:104] = CS_READ_CYCLES;
      csd_d[103:96] = CS_BUS_FREQ;
      csd_d[95:84] = CS_CMD_CLASSES;
      csd_d[83:80] = CS_BLOCK_LEN;
      csd_d[73:62] = CS_LEGACY_SIZE;
      csd_d[61:59] = CS_CURRENT;
      csd_d[58:56] = CS_CURRENT;
      csd_d[55:53] = CS_CURRENT;
      csd_d[52:50] = CS_CURRENT;
      csd_d[49:47] = CS_SIZE_MULT;
      csd_d[46:42] = CS_ERASE_GRP;
      csd_d[41:37] = CS_ERASE_MULT;
      csd_d[36:32] = CS_PROT_GRP;
      csd_d[31] = 1'b1;
      csd_d[28:26] = CS_WRITE_SPEED;
      csd_d[25:22] = CS_BLOCK_LEN;
      csd_d[15] = file_grp_q;
      csd_d[14] = copy_q;
      csd_d[13] = perm_prot_q;
      csd_d[12] = tmp_prot_q;
      csd_d[11:10] = file_fmt_q;
      csd_d[9:8] = ecc_q;
      csd_d[7:1] = crc7_of(csd_d[127:8]);
      csd_d[0] = 1'b1;

      // Saturate so an oversized enhanced area cannot wrap the capacity
      if (enh_sect_q >= EXT_SECTOR_COUNT)
      begin
         user_d = 32'h0000_0000;
      end
      else
      begin
         user_d = EXT_SECTOR_COUNT - enh_sect_q;
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      unique case (avs_address)
         OFS_OPCOND: rdata_d = ocr_d;
         OFS_IDENT0: rdata_d = cid_d[31:0];
         OFS_IDENT0 + 8'h04: rdata_d = cid_d[63:32];
         OFS_IDENT0 + 8'h08: rdata_d = cid_d[95:64];
         OFS_IDENT0 + 8'h0C: rdata_d = cid_d[127:96];
         OFS_SPEC0: rdata_d = csd_d[31:0];
         OFS_SPEC0 + 8'h04: rdata_d = csd_d[63:32];
         OFS_SPEC0 + 8'h08: rdata_d = csd_d[95:64];
         OFS_SPEC0 + 8'h0C: rdata_d = csd_d[127:96];
         OFS_WRFIELDS: rdata_d = {16'h0000, csd_d[15:0]};
         OFS_SERIAL: rdata_d = serial_q;
         OFS_DATEREV: rdata_d = {16'h0000, rev_q, date_q};
         OFS_ENHSECT: rdata_d = enh_sect_q;
         OFS_USERSECT: rdata_d = user_d;
         OFS_BUSWIDTH:
         begin
            unique case (width_q)
               CRS_BW_1: rdata_d = 32'h0000_0000;
               CRS_BW_4: rdata_d = 32'h0000_0001;
               CRS_BW_8: rdata_d = 32'h0000_0002;
            endcase
         end
         OFS_STATUS: rdata_d = {30'h0000_0000, link_seen_q, pwr_done_q};
         OFS_EXTSECT: rdata_d = EXT_SECTOR_COUNT;
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   // Read data is captured on the first edge of a read and held
   always_ff @(posedge mclk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         avs_readdata <= 32'h0000_0000;
      end
      else if (avs_read && !ack_q)
      begin
         avs_readdata <= rdata_d;
      end
   end

   // Registered images for the command engine
   always_ff @(posedge mclk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         operating_conditions <= 32'h0000_0000;
         card_identification <= '0;
         card_specific_data <= '0;
         user_sectors <= 32'h0000_0000;
         data_lines_en <= LINES_1;
      end
      else
      begin
         operating_conditions <= ocr_d;
         card_identification <= cid_d;
         card_specific_data <= csd_d;
         user_sectors <= user_d;
         unique case (width_q)
            CRS_BW_1: data_lines_en <= LINES_1;
            CRS_BW_4: data_lines_en <= LINES_4;
            CRS_BW_8: data_lines_en <= LINES_8;
         endcase
      end
   end
endmodule

// [design/crs_pkg.sv]
// Purpose: Constants shared by the card register set
// Assumes: Avalon-MM word addressing on byte addresses, 32-bit data
// Notes: Offsets are byte addresses of aligned words

package crs_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W = 128;

   // Register map
   localparam logic [7:0] OFS_OPCOND = 8'h00;
   localparam logic [7:0] OFS_IDENT0 = 8'h04;
   localparam logic [7:0] OFS_SPEC0 = 8'h14;
   localparam logic [7:0] OFS_WRFIELDS = 8'h24;
   localparam logic [7:0] OFS_CTRL = 8'h28;
   localparam logic [7:0] OFS_SERIAL = 8'h2C;
   localparam logic [7:0] OFS_DATEREV = 8'h30;
   localparam logic [7:0] OFS_ENHSECT = 8'h34;
   localparam logic [7:0] OFS_USERSECT = 8'h38;
   localparam logic [7:0] OFS_BUSWIDTH = 8'h3C;
   localparam logic [7:0] OFS_STATUS = 8'h40;
   localparam logic [7:0] OFS_EXTSECT = 8'h44;

   // Operating-conditions word fields
   localparam int unsigned OC_BUSY = 31;
   localparam logic [1:0] OC_ACCESS_SECTOR = 2'h2;
   localparam logic [8:0] OC_HIGH_RANGE = 9'h1FF;
   localparam logic OC_LOW_RANGE = 1'b1;

   // Identification fixed fields
   localparam logic [7:0] ID_MAKER = 8'hA5; // Arbitrary value
   localparam logic [47:0] ID_PRODUCT = 48'h0000_0000_0001; // Arbitrary value
   localparam logic [1:0] ID_PKG_EMBEDDED = 2'h1;

   // Card-specific fixed fields
   localparam logic [1:0] CS_STRUCT = 2'h3;
   localparam logic [3:0] CS_SPEC = 4'h4;
   localparam logic [7:0] CS_READ_TIME = 8'h0E;
   localparam logic [7:0] CS_READ_CYCLES = 8'h00;
   localparam logic [7:0] CS_BUS_FREQ = 8'h32;
   localparam logic [11:0] CS_CMD_CLASSES = 12'h0F5;
   localparam logic [3:0] CS_BLOCK_LEN = 4'h9;
   localparam logic [11:0] CS_LEGACY_SIZE = 12'hFFF;
   localparam logic [2:0] CS_CURRENT = 3'h7;
   localparam logic [2:0] CS_SIZE_MULT = 3'h7;
   localparam logic [4:0] CS_ERASE_GRP = 5'h1F;
   localparam logic [4:0] CS_ERASE_MULT = 5'h1F;
   localparam logic [4:0] CS_PROT_GRP = 5'h0F;
   localparam logic [2:0] CS_WRITE_SPEED = 3'h4;

   // Capacity
   localparam logic [31:0] EXT_SECTOR_COUNT = 32'h00E9_0000;

   // Checksum polynomial x^7 + x^3 + 1
   localparam logic [6:0] CRC7_POLY = 7'h09;

   // Power-up routine length in sampled link clock rising edges
   localparam logic [7:0] POWERUP_EDGES = 8'h4A;

   // Data line widths
   typedef enum logic [2:0]
   {
      CRS_BW_1 = 3'b001,
      CRS_BW_4 = 3'b010,
      CRS_BW_8 = 3'b100
   } crs_width_e;
   localparam logic [7:0] LINES_1 = 8'h01;
   localparam logic [7:0] LINES_4 = 8'h0F;
   localparam logic [7:0] LINES_8 = 8'hFF;
endpackage

// [verif/crs_card_register_set_chk.sv]
// Purpose: Port assertions for the card register set
// Assumes: One mclk domain, rst_b active low
// Notes: Image checks wait for image bit 0, which stays low until the first image registered after the synchronised reset releases
`timescale 1ns/1ps
module crs_card_register_set_chk
   import crs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [crs_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [crs_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [crs_pkg::DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic link_clk,
   input wire logic [31:0] operating_conditions,
   input wire logic [crs_pkg::REG_W-1:0] card_identification,
   input wire logic [crs_pkg::REG_W-1:0] card_specific_data,
   input wire logic [7:0] data_lines_en,
   input wire logic [31:0] user_sectors
);
   logic [7:0] edges_q;
   logic link_q;

   function automatic logic [6:0] crc7(input logic [119:0] v);
      logic [6:0] c;
      c = 7'h00;
      for (int i = 119; i >= 0; i--)
         c = {c[5:0], 1'b0} ^ ((v[i] ^ c[6]) ? 7'h09 : 7'h00);
      return c;
   endfunction

   // Raw pin edges: never fewer than the design's synchronised count
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         edges_q <= 8'h00;
         link_q <= 1'b0;
      end
      else
      begin
         link_q <= link_clk;
         if (link_clk && !link_q && edges_q != 8'hFF)
            edges_q <= edges_q + 8'h01;
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);

   sequence width_code_four;
      avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == OFS_BUSWIDTH
         && avs_writedata[1:0] == 2'h1;
   endsequence

   chk_opcond_window: assert property (
      card_identification[0] |-> operating_conditions[30:0] ==
         {OC_ACCESS_SECTOR, 5'h00, OC_HIGH_RANGE, 7'h00, OC_LOW_RANGE, 7'h00})
      else $error("operating word window or access mode wrong");
   chk_busy_wait: assert property (
      $rose(operating_conditions[31]) |-> edges_q >= POWERUP_EDGES)
      else $error("busy bit set before power-up finished");
   chk_busy_hold: assert property (
      operating_conditions[31] |=> operating_conditions[31])
      else $error("busy bit dropped");
   chk_ident_fixed: assert property (
      card_identification[0] |-> card_identification[119:104] == 16'h0100)
      else $error("identification package or reserved field wrong");
   chk_ident_crc: assert property (
      card_identification[0] |-> card_identification[7:1] == crc7(card_identification[127:8]))
      else $error("identification checksum wrong");
   chk_spec_crc: assert property (
      card_specific_data[0] |-> card_specific_data[7:1] == crc7(card_specific_data[127:8]))
      else $error("card-specific checksum wrong");
   chk_spec_fixed: assert property (
      card_specific_data[0] |-> card_specific_data[127:96] == 32'hD00E_0032
         && card_specific_data[95:16] == {12'h0F5, 4'h9, 6'h00, 12'hFFF, 15'h7FFF,
         5'h1F, 5'h1F, 5'h0F, 1'b1, 2'h0, 3'h4, 4'h9, 6'h00})
      else $error("card-specific fixed field wrong");
   chk_copy_sticky: assert property (
      card_specific_data[14] |=> card_specific_data[14])
      else $error("copy flag cleared");
   chk_lines_code: assert property (
      width_code_four |-> ##[1:3] data_lines_en == LINES_4)
      else $error("four-line enable not applied");
endmodule

// [verif/crs_host_link.sv]
// Purpose: Host side of the link, makes the bus clock in bursts
// Assumes: 320 ns link period
// Notes: Clock parks low between bursts, as a host does outside frames
`timescale 1ns/1ps
module crs_host_link
(
   output logic link_clk
);
   initial link_clk = 1'b0;

   // Bursts pace the device's power-up count
   task automatic burst(input int n);
      repeat (n)
      begin
         #160 link_clk = 1'b1;
         #160 link_clk = 1'b0;
      end
   endtask
endmodule

// [verif/tb_top.sv]
// Purpose: Self-checking bench for the card register set
// Assumes: Avalon-MM master with NBA drive, host link model
// Notes: Expected images are rebuilt here from the field values
`timescale 1ns/1ps
module tb_top;
   import crs_pkg::*;
   logic mclk, rst_b, avs_read, avs_write, avs_waitrequest, link_clk;
   logic [7:0] avs_address, data_lines_en;
   logic [31:0] avs_writedata, avs_readdata, operating_conditions, user_sectors, rd;
   logic [3:0] avs_byteenable;
   logic [127:0] card_identification, card_specific_data;
   int num_errors, check_count;

   crs_card_register_set crs_card_register_set_i (.mclk, .rst_b, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .link_clk,
      .operating_conditions, .card_identification, .card_specific_data, .data_lines_en,
      .user_sectors);
   crs_host_link crs_host_link_i (.link_clk);

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   function automatic logic [6:0] crc7(input logic [119:0] v);
      logic [6:0] c;
      c = 7'h00;
      for (int i = 119; i >= 0; i--)
         c = {c[5:0], 1'b0} ^ ((v[i] ^ c[6]) ? 7'h09 : 7'h00);
      return c;
   endfunction

   function automatic logic [127:0] exp_cid(input logic [31:0] sn, input logic [7:0] dt,
      input logic [7:0] rv);
      logic [119:0] b;
      b = {ID_MAKER, 6'h00, 2'h1, 8'h00, ID_PRODUCT, rv, sn, dt};
      return {b, crc7(b), 1'b1};
   endfunction

   function automatic logic [127:0] exp_csd(input logic [7:0] wf);
      logic [119:0] b;
      b = {32'hD00E_0032, 12'h0F5, 4'h9, 6'h00, 12'hFFF, 15'h7FFF, 5'h1F, 5'h1F, 5'h0F, 1'b1,
         2'h0, 3'h4, 4'h9, 6'h00, wf};
      return {b, crc7(b), 1'b1};
   endfunction

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t word %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_wide(input logic [127:0] got, input logic [127:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t image %h expected %h", $time, got, exp);
      end
   endtask

   // No wait limit here: the watchdog ends a hung transfer
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do
         @(posedge mclk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic spec_step(input logic [7:0] a, input logic [31:0] d, input logic [7:0] wf);
      logic [127:0] e;
      bus(1'b1, a, d);
      repeat (3) @(posedge mclk);
      e = exp_csd(wf);
      chk_wide(card_specific_data, e);
      bus(1'b0, OFS_WRFIELDS, 32'h0000_0000);
      chk_word(rd, {16'h0000, e[15:0]});
   endtask

   task automatic t_spec;
      spec_step(8'h80, 32'hFFFF_FFFF, 8'h00);
      bus(1'b0, 8'h80, 32'h0000_0000);
      chk_word(rd, 32'h0000_0000);
      spec_step(OFS_WRFIELDS, 32'h0000_9F00, 8'h9F);
      spec_step(OFS_CTRL, 32'h0000_0001, 8'h8C);
      spec_step(OFS_WRFIELDS, 32'h0000_6000, 8'h60);
      spec_step(OFS_WRFIELDS, 32'h0000_0000, 8'h60);
      bus(1'b0, OFS_SPEC0 + 8'h0C, 32'h0000_0000);
      chk_word(rd, 32'hD00E_0032);
   endtask

   task automatic t_ident;
      logic [127:0] e;
      chk_wide(card_identification, exp_cid(32'h0000_0000, 8'h00, 8'h00));
      bus(1'b1, OFS_SERIAL, 32'h1234_5678);
      bus(1'b1, OFS_DATEREV, 32'h0000_ABCD);
      repeat (3) @(posedge mclk);
      e = exp_cid(32'h1234_5678, 8'hCD, 8'hAB);
      chk_wide(card_identification, e);
      for (int w = 0; w < 4; w++)
      begin
         bus(1'b0, OFS_IDENT0 + 8'(4 * w), 32'h0000_0000);
         chk_word(rd, e[32 * w +: 32]);
      end
   endtask

   task automatic t_width;
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b1, OFS_BUSWIDTH, 32'(i));
         repeat (3) @(posedge mclk);
         chk_word({24'h00_0000, data_lines_en},
            (i == 0) ? 32'h0000_0001 : (i == 1) ? 32'h0000_000F : 32'h0000_00FF);
      end
   endtask

   task automatic t_sectors;
      bus(1'b0, OFS_EXTSECT, 32'h0000_0000);
      chk_word(rd, 32'h00E9_0000);
      bus(1'b0, OFS_USERSECT, 32'h0000_0000);
      chk_word(rd, 32'h00E9_0000);
      bus(1'b1, OFS_ENHSECT, 32'h0001_0000);
      repeat (3) @(posedge mclk);
      chk_word(user_sectors, 32'h00E8_0000);
      bus(1'b1, OFS_ENHSECT, 32'h00E9_0001);
      repeat (3) @(posedge mclk);
      chk_word(user_sectors, 32'h0000_0000);
   endtask

   task automatic t_powerup;
      bus(1'b0, OFS_STATUS, 32'h0000_0000);
      chk_word(rd, 32'h0000_0000);
      crs_host_link_i.burst(70);
      repeat (8) @(posedge mclk);
      chk_word(operating_conditions, 32'h40FF_8080);
      crs_host_link_i.burst(10);
      repeat (8) @(posedge mclk);
      bus(1'b1, OFS_OPCOND, 32'h0000_0000);
      bus(1'b0, OFS_OPCOND, 32'h0000_0000);
      chk_word(rd, 32'hC0FF_8080);
      bus(1'b0, OFS_STATUS, 32'h0000_0000);
      chk_word(rd, 32'h0000_0003);
   endtask

   // Mid-run reset: busy restarts low and host-written fields return to zero
   task automatic t_reset;
      rst_b <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      chk_word(operating_conditions, 32'h40FF_8080);
      chk_wide(card_specific_data, exp_csd(8'h00));
      bus(1'b0, OFS_STATUS, 32'h0000_0000);
      chk_word(rd, 32'h0000_0000);
   endtask

   task automatic tally_and_finish;
      $display("Errors %0d, checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      #400_000;
      num_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      tally_and_finish();
   end

   initial
   begin
      rst_b = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 8'h00;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      t_spec();
      t_ident();
      t_width();
      t_sectors();
      t_powerup();
      t_reset();
      tally_and_finish();
   end
endmodule

bind crs_card_register_set crs_card_register_set_chk crs_card_register_set_chk_i (.mclk, .rst_b,
   .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
   .avs_waitrequest, .link_clk, .operating_conditions, .card_identification,
   .card_specific_data, .data_lines_en, .user_sectors);
